/* tpc_pkg.sv */
// tpc_pkg: register map, field layouts, reset values and timing counts
// for the tuner peripheral control register bank.
// assumes a 20 MHz system clock and one AHB-Lite master.
package tpc_pkg;

   // ----------------------------------------------------------------
   // clock and unlock persistence times
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 50;      // 20 MHz system clock
   localparam int unsigned UNLOCK_T1_NS   = 1000;    // code 00: 1 us
   localparam int unsigned UNLOCK_T2_NS   = 2000;    // code 01: 2 us
   localparam int unsigned UNLOCK_T05_NS  = 500;     // code 10: 0.5 us
   // least times, rounded up to whole cycles
   localparam int unsigned UNLOCK_C1   = (UNLOCK_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned UNLOCK_C2   = (UNLOCK_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned UNLOCK_C05  = (UNLOCK_T05_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RUN_W       = 6;          // persistence counter width

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_UNLOCK_FLAG = 8'h05;   // pll_unlock_flag
   localparam logic [7:0] IDX_ADC_CMP     = 8'h06;   // adc_compare_result
   localparam logic [7:0] IDX_PWM_FUNC    = 8'h13;   // pwm_pin_function
   localparam logic [7:0] IDX_ADC_CH      = 8'h14;   // adc_channel_select
   localparam logic [7:0] IDX_UNLOCK_DLY  = 8'h15;   // pll_unlock_delay
   localparam logic [7:0] IDX_PLL_MODE    = 8'h21;   // pll_division_mode
   localparam logic [7:0] IDX_GRP_C_DIR   = 8'h27;   // port_group_c_direction
   localparam logic [7:0] IDX_REF_SEL     = 8'h31;   // pll_reference_select
   localparam logic [7:0] IDX_P1A_DIR     = 8'h35;   // port_1a_direction
   localparam logic [7:0] IDX_P0B_DIR     = 8'h36;   // port_0b_direction
   localparam logic [7:0] IDX_P0A_DIR     = 8'h37;   // port_0a_direction
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h40;   // sticky event bits
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h41;   // event enables

   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [1:0] RST_UNLOCK_DLY  = 2'h0;
   localparam logic [1:0] RST_PLL_MODE    = 2'h0;
   localparam logic [3:0] RST_REF_SEL     = 4'hf;    // reference off
   localparam logic [3:0] RST_ADC_CH      = 4'h7;    // pins are input port
   localparam logic [3:0] RST_PWM_FUNC    = 4'h0;
   localparam logic [3:0] RST_DIR         = 4'h0;    // all pins input
   localparam logic [1:0] RST_IRQ         = 2'h0;
   localparam logic [1:0] DLY_DISABLE     = 2'h3;    // flag never sets
   localparam logic [3:0] ADC_CH_LAST     = 4'h5;    // highest analog input
   localparam int unsigned IRQ_UNLOCK     = 0;       // status bit: unlock flagged
   localparam int unsigned IRQ_CMP        = 1;       // status bit: compare changed

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] division_mode;   // 00 off, 01 mf, 10 vhf, 11 hf
      logic [3:0] reference;       // reference frequency code
   } tpc_pll_ctrl_t;

   typedef struct packed {
      logic [3:0] grp_c;           // port 0c, all four together
      logic [3:0] p1a;
      logic [3:0] p0b;
      logic [3:0] p0a;
   } tpc_port_dir_t;

   typedef struct packed {
      logic [2:0] dac_output_enable;  // pwm2..pwm0 act as d/a outputs
      logic       clockgen_pin_enable; // clock generator pin function
   } tpc_pin_func_t;

endpackage

/* tpc_regs.sv */
// tpc_regs: tuner peripheral control register bank behind an AHB-Lite slave.
// assumes synchronous analog status inputs and a single master whose
// hready is this slave's hreadyout.
`timescale 1ns/1ps

// Notes on behaviour
// - unlock flag readable, cleared on read
// - delay code sets unlock persistence time
// - mode field picks divider method, resets zero
// - reference field selects reference frequency code
// - channel codes 0-5 route analog, 7 port
// - one bit sets port 0c direction
// - per-bit direction for ports 1a, 0b, 0a
// - pwm bits choose d/a or port output
// - bit 0 chooses clock generator pin function
module tpc_regs (
   // ahb-lite slave
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // analog status
   input  wire logic                   pll_unlock_detect,
   input  wire logic                   adc_compare_in,
   // peripheral controls
   output tpc_pkg::tpc_pll_ctrl_t      pll_ctrl,
   output logic      [3:0]             adc_channel,
   output logic                        adc_route_enable,
   output tpc_pkg::tpc_port_dir_t      port_dir,
   output tpc_pkg::tpc_pin_func_t      pin_func,
   // interrupt
   output logic                        irq
);
   import tpc_pkg::*;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic             unlock_flag_bit;     // sticky unlock flag
   logic [1:0]       unlock_delay_field;  // persistence code
   logic [1:0]       division_mode_bit;   // divider method
   logic [3:0]       reference_select;    // reference code
   logic [3:0]       channel_select;      // converter channel
   logic             compare_result_bit;  // sampled comparator
   logic             group_direction_bit; // port 0c direction
   logic [3:0]       p1a_dir;             // port 1a direction
   logic [3:0]       p0b_dir;             // port 0b direction
   logic [3:0]       p0a_dir;             // port 0a direction
   logic [3:0]       pwm_function;        // pwm and clock pin function
   logic [1:0]       irq_status;          // sticky events
   logic [1:0]       irq_mask;            // event enables
   logic [RUN_W-1:0] run_cnt;             // cycles of unlock so far

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic       bus_take;   // address phase accepted
   logic [7:0] addr_idx;   // register index of the address phase
   logic       wr_pend;    // write data phase pending
   logic [7:0] wr_idx;     // index of the pending write
   logic       rd_flag;    // read of unlock flag accepted now
   logic       set_unlock; // flag sets this cycle
   logic       cmp_change; // comparator moved

   assign bus_take = hsel & hready & htrans[1];
   assign addr_idx = haddr[9:2];
   assign rd_flag  = bus_take & ~hwrite & (addr_idx == IDX_UNLOCK_FLAG);

   // required persistence, in cycles, for a delay code
   function automatic logic [RUN_W-1:0] need_cycles(input logic [1:0] code);
      logic [RUN_W-1:0] n;
      n = RUN_W'(UNLOCK_C1);
      case (code)
         2'h0:    n = RUN_W'(UNLOCK_C1);
         2'h1:    n = RUN_W'(UNLOCK_C2);
         2'h2:    n = RUN_W'(UNLOCK_C05);
         default: n = RUN_W'(UNLOCK_C1);
      endcase
      return n;
   endfunction

   // read data for an index; unused bits read as zero
   function automatic logic [31:0] read_mux(input logic [7:0] idx);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (idx)
         IDX_UNLOCK_FLAG: d[0]   = unlock_flag_bit;
         IDX_ADC_CMP:     d[0]   = compare_result_bit;
         IDX_PWM_FUNC:    d[3:0] = pwm_function;
         IDX_ADC_CH:      d[3:0] = channel_select;
         IDX_UNLOCK_DLY:  d[1:0] = unlock_delay_field;
         IDX_PLL_MODE:    d[1:0] = division_mode_bit;
         IDX_GRP_C_DIR:   d[0]   = group_direction_bit;
         IDX_REF_SEL:     d[3:0] = reference_select;
         IDX_P1A_DIR:     d[3:0] = p1a_dir;
         IDX_P0B_DIR:     d[3:0] = p0b_dir;
         IDX_P0A_DIR:     d[3:0] = p0a_dir;
         IDX_IRQ_STATUS:  d[1:0] = irq_status;
         IDX_IRQ_MASK:    d[1:0] = irq_mask;
         default:         d      = 32'h0000_0000;
      endcase
      return d;
   endfunction

   // ----------------------------------------------------------------
   // ahb-lite response
   // ----------------------------------------------------------------
   // zero wait states, always okay; unmapped reads give zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // read data captured at the address phase, shown in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (bus_take && !hwrite) begin
         hrdata <= read_mux(addr_idx);
      end
   end

   // remember an accepted write for its data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx  <= 8'h00;
      end else begin
         wr_pend <= bus_take & hwrite;
         if (bus_take) begin
            wr_idx <= addr_idx;
         end
      end
   end

   // ----------------------------------------------------------------
   // writable control registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unlock_delay_field  <= RST_UNLOCK_DLY;
         division_mode_bit   <= RST_PLL_MODE;
         reference_select    <= RST_REF_SEL;
         channel_select      <= RST_ADC_CH;
         group_direction_bit <= RST_DIR[0];
         p1a_dir             <= RST_DIR;
         p0b_dir             <= RST_DIR;
         p0a_dir             <= RST_DIR;
         pwm_function        <= RST_PWM_FUNC;
         irq_mask            <= RST_IRQ;
      end else if (wr_pend) begin
         case (wr_idx)
            IDX_UNLOCK_DLY: unlock_delay_field  <= hwdata[1:0];
            IDX_PLL_MODE:   division_mode_bit   <= hwdata[1:0];
            IDX_REF_SEL:    reference_select    <= hwdata[3:0];
            IDX_ADC_CH:     channel_select      <= hwdata[3:0];
            IDX_GRP_C_DIR:  group_direction_bit <= hwdata[0];
            IDX_P1A_DIR:    p1a_dir             <= hwdata[3:0];
            IDX_P0B_DIR:    p0b_dir             <= hwdata[3:0];
            IDX_P0A_DIR:    p0a_dir             <= hwdata[3:0];
            IDX_PWM_FUNC:   pwm_function        <= hwdata[3:0];
            IDX_IRQ_MASK:   irq_mask            <= hwdata[1:0];
            default:        irq_mask            <= irq_mask;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // unlock detection
   // ----------------------------------------------------------------
   // counts consecutive unlocked cycles; any lock restarts it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_cnt <= '0;
      end else if (!pll_unlock_detect) begin
         run_cnt <= '0;
      end else if (run_cnt != need_cycles(unlock_delay_field)) begin
         run_cnt <= run_cnt + RUN_W'(1);
      end
   end

   // set once the unlock has lasted the chosen time, never when disabled
   assign set_unlock = pll_unlock_detect
                     & (unlock_delay_field != DLY_DISABLE)
                     & (run_cnt == need_cycles(unlock_delay_field) - RUN_W'(1));

   // sticky flag; a read clears it but a same-cycle set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unlock_flag_bit <= 1'b0;
      end else if (set_unlock) begin
         unlock_flag_bit <= 1'b1;
      end else if (rd_flag) begin
         unlock_flag_bit <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // comparator sampling
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_result_bit <= 1'b0;
      end else begin
         compare_result_bit <= adc_compare_in;
      end
   end

   assign cmp_change = compare_result_bit ^ adc_compare_in;

   // ----------------------------------------------------------------
   // interrupt status, write one to clear, set wins
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status <= RST_IRQ;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == IRQ_UNLOCK && set_unlock) || (i == IRQ_CMP && cmp_change)) begin
               irq_status[i] <= 1'b1;
            end else if (wr_pend && wr_idx == IDX_IRQ_STATUS && hwdata[i]) begin
               irq_status[i] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_ctrl         <= '{division_mode: RST_PLL_MODE, reference: RST_REF_SEL};
         adc_channel      <= RST_ADC_CH;
         adc_route_enable <= 1'b0;
         port_dir         <= '0;
         pin_func         <= '0;
         irq              <= 1'b0;
      end else begin
         pll_ctrl.division_mode <= division_mode_bit;
         pll_ctrl.reference     <= reference_select;
         adc_channel            <= channel_select;
         adc_route_enable       <= (channel_select <= ADC_CH_LAST);
         port_dir.grp_c         <= {4{group_direction_bit}};
         port_dir.p1a           <= p1a_dir;
         port_dir.p0b           <= p0b_dir;
         port_dir.p0a           <= p0a_dir;
         pin_func.dac_output_enable   <= pwm_function[3:1];
         pin_func.clockgen_pin_enable <= pwm_function[0];
         irq                    <= |(irq_status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_flag_read;
      rd_flag && !set_unlock;
   endsequence

   sequence s_write(logic [7:0] idx);
      bus_take && hwrite && addr_idx == idx;
   endsequence

   property p_flag_clear;
      @(posedge hclk) disable iff (!hresetn)
      s_flag_read |=> !unlock_flag_bit;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by read");

   property p_flag_read_data;
      @(posedge hclk) disable iff (!hresetn)
      bus_take && !hwrite && addr_idx == IDX_UNLOCK_FLAG
         |=> hrdata == {31'h0, $past(unlock_flag_bit)};
   endproperty
   a_flag_read_data: assert property (p_flag_read_data) else $error("flag read data wrong");

   property p_delay_disabled;
      @(posedge hclk) disable iff (!hresetn)
      unlock_delay_field == DLY_DISABLE && !unlock_flag_bit |=> !unlock_flag_bit;
   endproperty
   a_delay_disabled: assert property (p_delay_disabled) else $error("flag set while disabled");

   property p_delay_1us;
      @(posedge hclk) disable iff (!hresetn)
      unlock_delay_field == 2'h0 && !unlock_flag_bit && !pll_unlock_detect
         ##1 pll_unlock_detect [*8] |-> !set_unlock;
   endproperty
   a_delay_1us: assert property (p_delay_1us) else $error("flag set before 1 us");

   property p_mode_write;
      @(posedge hclk) disable iff (!hresetn)
      s_write(IDX_PLL_MODE) ##2 1'b1 |=> pll_ctrl.division_mode == $past(hwdata[1:0], 2);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("division mode not applied");

   property p_ref_write;
      @(posedge hclk) disable iff (!hresetn)
      s_write(IDX_REF_SEL) ##2 1'b1 |=> pll_ctrl.reference == $past(hwdata[3:0], 2);
   endproperty
   a_ref_write: assert property (p_ref_write) else $error("reference not applied");

   property p_route;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> adc_route_enable == ($past(channel_select) <= ADC_CH_LAST);
   endproperty
   a_route: assert property (p_route) else $error("channel routing wrong");

   property p_cmp_read;
      @(posedge hclk) disable iff (!hresetn)
      bus_take && !hwrite && addr_idx == IDX_ADC_CMP |=> hrdata[0] == $past(adc_compare_in, 2);
   endproperty
   a_cmp_read: assert property (p_cmp_read) else $error("compare read wrong");

   property p_group_c;
      @(posedge hclk) disable iff (!hresetn)
      s_write(IDX_GRP_C_DIR) ##2 1'b1 |=> port_dir.grp_c == {4{$past(hwdata[0], 2)}};
   endproperty
   a_group_c: assert property (p_group_c) else $error("group c direction wrong");

   property p_p0a;
      @(posedge hclk) disable iff (!hresetn)
      s_write(IDX_P0A_DIR) ##2 1'b1 |=> port_dir.p0a == $past(hwdata[3:0], 2);
   endproperty
   a_p0a: assert property (p_p0a) else $error("port 0a direction wrong");

   property p_pwm;
      @(posedge hclk) disable iff (!hresetn)
      s_write(IDX_PWM_FUNC) ##2 1'b1
         |=> pin_func.dac_output_enable == $past(hwdata[3:1], 2)
             && pin_func.clockgen_pin_enable == $past(hwdata[0], 2);
   endproperty
   a_pwm: assert property (p_pwm) else $error("pin function wrong");

endmodule

/* tpc_regs_test.sv */
// tpc_regs_test: self-checking bench for the tuner peripheral control bank.
// assumes tpc_pkg and tpc_regs are compiled first; the bench is the only bus master.
`timescale 1ns/1ps
module tpc_regs_test;
   import tpc_pkg::*;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int TIMEOUT = 5000;           // far above the few hundred cycles used
   logic                  hclk;             // 20 mhz system clock
   logic                  hresetn;          // async reset, active low
   logic                  hsel;             // slave select
   logic           [31:0] haddr;            // byte address
   logic           [1:0]  htrans;           // idle or nonseq
   logic                  hwrite;           // write strobe
   logic           [2:0]  hsize;            // always a word
   logic           [31:0] hwdata;           // write data
   wire logic             hready;           // bus ready, from the one slave
   logic           [31:0] hrdata;           // read data
   logic                  hreadyout;        // slave ready
   logic                  hresp;            // slave response
   logic                  pll_unlock_detect; // loop unlocked level
   logic                  adc_compare_in;   // comparator level
   tpc_pll_ctrl_t         pll_ctrl;         // divider and reference codes
   logic           [3:0]  adc_channel;      // channel copy
   logic                  adc_route_enable; // analog routing on
   tpc_port_dir_t         port_dir;         // pin directions
   tpc_pin_func_t         pin_func;         // pwm and clock pin functions
   logic                  irq;              // level interrupt
   int                    error_cnt;        // mismatches seen
   int                    check_count;      // comparisons made
   int                    cycles;           // watchdog count

   assign hready = hreadyout;

   tpc_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pll_unlock_detect(pll_unlock_detect), .adc_compare_in(adc_compare_in),
      .pll_ctrl(pll_ctrl), .adc_channel(adc_channel), .adc_route_enable(adc_route_enable),
      .port_dir(port_dir), .pin_func(pin_func), .irq(irq));

   // ----------------------------------------------------------------
   // clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // a hang counts as a mismatch and ends the run
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT) begin
         error_cnt++;
         final_report();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // one comparison of a zero-extended value
   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one single-word transfer: address phase, then data phase
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      check_word("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic wr_reg(input logic [7:0] idx, input logic [31:0] data);
      logic [31:0] d;
      bus(idx, 1'b1, data, d);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      bus(idx, 1'b0, 32'h0, d);
      check_word($sformatf("reg %h", idx), exp, d);
   endtask

   // outputs follow a register one edge after the write ends; wait two edges
   task automatic settle();
      repeat (2) @(posedge hclk);
   endtask

   // two reads under persistence n-1 and n, then clear on read
   task automatic unlock_run(input logic [1:0] code, input int n);
      wr_reg(IDX_UNLOCK_DLY, {30'h0, code});
      rd_chk(IDX_UNLOCK_FLAG, 32'h0);
      pll_unlock_detect <= 1'b1;
      repeat (n - 1) @(posedge hclk);
      pll_unlock_detect <= 1'b0;
      rd_chk(IDX_UNLOCK_FLAG, 32'h0);
      pll_unlock_detect <= 1'b1;
      repeat (n) @(posedge hclk);
      pll_unlock_detect <= 1'b0;
      rd_chk(IDX_UNLOCK_FLAG, (code == DLY_DISABLE) ? 32'h0 : 32'h1);
      rd_chk(IDX_UNLOCK_FLAG, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // register tables: index, reset value, stored bits
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_TAB [13] = '{IDX_UNLOCK_FLAG, IDX_ADC_CMP, IDX_PWM_FUNC,
      IDX_ADC_CH, IDX_UNLOCK_DLY, IDX_PLL_MODE, IDX_GRP_C_DIR, IDX_REF_SEL, IDX_P1A_DIR,
      IDX_P0B_DIR, IDX_P0A_DIR, IDX_IRQ_STATUS, IDX_IRQ_MASK};
   localparam logic [3:0] RST_TAB [13] = '{4'h0, 4'h0, 4'h0, 4'h7, 4'h0, 4'h0, 4'h0, 4'hf,
      4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
   localparam logic [3:0] MSK_TAB [13] = '{4'h0, 4'h0, 4'hf, 4'hf, 4'h3, 4'h3, 4'h1, 4'hf,
      4'hf, 4'hf, 4'hf, 4'h0, 4'h3};

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; pll_unlock_detect = 1'b0; adc_compare_in = 1'b0;
      error_cnt = 0; check_count = 0; cycles = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values of every register and of every output except irq
      for (int i = 0; i < 13; i++) rd_chk(IDX_TAB[i], {28'h0, RST_TAB[i]});
      check_word("pll_ctrl", {26'h0, 2'h0, 4'hf}, {26'h0, pll_ctrl});
      check_word("channel", {27'h0, 1'b0, 4'h7}, {27'h0, adc_route_enable, adc_channel});
      check_word("port_dir", 32'h0, {16'h0, port_dir});
      check_word("pin_func", 32'h0, {28'h0, pin_func});
      // stored bits only, upper bits zero; codes 9..b are never written
      for (int i = 2; i <= 10; i++) wr_reg(IDX_TAB[i], 32'hffff_fffc);
      for (int i = 2; i <= 10; i++) rd_chk(IDX_TAB[i], {28'h0, 4'hc & MSK_TAB[i]});
      for (int i = 2; i <= 10; i++) wr_reg(IDX_TAB[i], 32'hffff_fff3);
      for (int i = 2; i <= 10; i++) rd_chk(IDX_TAB[i], {28'h0, 4'h3 & MSK_TAB[i]});
      settle();
      check_word("port_dir", {16'h0, 16'hf333}, {16'h0, port_dir});
      check_word("pin_func", 32'h3, {28'h0, pin_func});
      wr_reg(IDX_PWM_FUNC, 32'ha);
      wr_reg(IDX_GRP_C_DIR, 32'h0);
      wr_reg(IDX_P1A_DIR, 32'h5);
      settle();
      check_word("pin_func", 32'ha, {28'h0, pin_func});
      check_word("port_dir", {16'h0, 16'h0533}, {16'h0, port_dir});
      // every division mode, every allowed reference code
      for (int m = 0; m < 4; m++) begin
         wr_reg(IDX_PLL_MODE, m);
         settle();
         check_word("division_mode", m, {30'h0, pll_ctrl.division_mode});
      end
      for (int c = 0; c < 16; c++) begin
         if (c < 9 || c > 11) begin
            wr_reg(IDX_REF_SEL, c);
            settle();
            check_word("reference", c, {28'h0, pll_ctrl.reference});
         end
      end
      // channel routing for codes 0..7
      for (int c = 0; c < 8; c++) begin
         wr_reg(IDX_ADC_CH, c);
         settle();
         check_word("channel", {27'h0, c <= 5, c[3:0]}, {27'h0, adc_route_enable, adc_channel});
      end
      // unlock persistence per delay code
      unlock_run(2'h0, 20);
      unlock_run(2'h1, 40);
      unlock_run(2'h2, 10);
      unlock_run(2'h3, 50);
      // unlock event: masked, unmasked, cleared
      rd_chk(IDX_IRQ_STATUS, 32'h1);
      settle();
      check_word("irq", 32'h0, {31'h0, irq});
      wr_reg(IDX_IRQ_MASK, 32'h1);
      settle();
      check_word("irq", 32'h1, {31'h0, irq});
      wr_reg(IDX_IRQ_STATUS, 32'h1);
      settle();
      check_word("irq", 32'h0, {31'h0, irq});
      // comparator result and its change event
      adc_compare_in <= 1'b1;
      repeat (3) @(posedge hclk);
      rd_chk(IDX_ADC_CMP, 32'h1);
      rd_chk(IDX_IRQ_STATUS, 32'h2);
      wr_reg(IDX_IRQ_MASK, 32'h3);
      settle();
      check_word("irq", 32'h1, {31'h0, irq});
      wr_reg(IDX_IRQ_STATUS, 32'h2);
      settle();
      check_word("irq", 32'h0, {31'h0, irq});
      adc_compare_in <= 1'b0;
      repeat (3) @(posedge hclk);
      rd_chk(IDX_ADC_CMP, 32'h0);
      // unmapped place reads zero, write ignored
      wr_reg(8'h3f, 32'hffff_ffff);
      rd_chk(8'h3f, 32'h0);
      final_report();
   end
endmodule
